// ### tmc_map.vh
`ifndef TMC_MAP_VH
`define TMC_MAP_VH
// mode field codes
`define TMC_MODE_STOP      2'b00
`define TMC_MODE_FREE      2'b01
`define TMC_MODE_CLR_EDGE  2'b10
`define TMC_MODE_CLR_MATCH 2'b11
// output preset pair {high, low}
`define TMC_PRESET_KEEP    2'b00
`define TMC_PRESET_LOW     2'b01
`define TMC_PRESET_HIGH    2'b10
// edge select codes {hi, lo}
`define TMC_EDGE_FALL      2'b00
`define TMC_EDGE_RISE      2'b01
`define TMC_EDGE_BOTH      2'b11
// prescaler select: count clock = peripheral clock / 2^(sel+1)
`define TMC_PRESCALE_W     3
// consecutive samples that make an edge valid
`define TMC_FILTER_SAMPLES 2
`define TMC_CNT_MAX        16'hFFFF
`define TMC_CNT_ZERO       16'h0000
`define TMC_CNT_ONE        16'h0001
// register offsets
`define TMC_REG_CTRL       4'h0
`define TMC_REG_OUTCTL     4'h1
`define TMC_REG_CAPCTL     4'h2
`define TMC_REG_PRESCALE   4'h3
`define TMC_REG_COUNT      4'h4
`define TMC_REG_CCA        4'h5
`define TMC_REG_CCB        4'h6
`define TMC_REG_STATUS     4'h7
// control register fields
`define TMC_CTRL_OVF       0
`define TMC_CTRL_MODE_LO   2
`define TMC_CTRL_MODE_HI   3
// output control fields
`define TMC_OC_TOGGLE_A    0
`define TMC_OC_PRESET_LOW  2
`define TMC_OC_PRESET_HIGH 3
`define TMC_OC_TOGGLE_B    4
`define TMC_OC_ONESHOT_EN  5
`define TMC_OC_ONESHOT_TRG 6
// capture control fields
`define TMC_CC_A_CAPTURE   0
`define TMC_CC_A_REVERSE   1
`define TMC_CC_B_CAPTURE   2
`define TMC_CC_EDGE_A_LO   4
`define TMC_CC_EDGE_A_HI   5
`define TMC_CC_EDGE_B_LO   6
`define TMC_CC_EDGE_B_HI   7
// prescaler register fields
`define TMC_PR_EXT_CLK     3
`endif

// ### tmc_prescaler.v
`timescale 1ns/1ps
// divides the peripheral clock, emitting a one-cycle rise and fall tick of the count clock
module tmc_prescaler #(
    parameter SEL_W = 3
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             ce,
    input  wire             run,
    input  wire [SEL_W-1:0] sel,
    output reg              rise_tick,
    output reg              fall_tick
);
    reg  [7:0] div;
    wire [7:0] half = 8'h01 << sel;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div       <= 8'h00;
            rise_tick <= 1'b0;
            fall_tick <= 1'b0;
        end else if (ce) begin
            // counting starts whenever run rises, not aligned to the tick
            if (!run) begin
                div       <= 8'h00;
                rise_tick <= 1'b0;
                fall_tick <= 1'b0;
            end else begin
                div       <= div + 8'h01;
                rise_tick <= ((div & ((half << 1) - 8'h01)) == ((half << 1) - 8'h01));
                fall_tick <= ((div & ((half << 1) - 8'h01)) == (half - 8'h01));
            end
        end
    end
endmodule

// ### tmc_edge_filter.v
`timescale 1ns/1ps
`include "tmc_map.vh"
// two-sample noise filter with edge select; first enable after reset sees a high level as rising
module tmc_edge_filter (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       ce,
    input  wire       run,
    input  wire       sample,
    input  wire       pin,
    input  wire [1:0] edge_sel,
    output reg        valid_edge,
    output reg        reverse_edge
);
    reg s1;
    reg s2;
    reg level;
    reg first_done;
    wire rise = s1 & s2 & ~level;
    wire fall = ~s1 & ~s2 & level;
    wire want_rise = edge_sel[0];
    wire want_fall = (edge_sel == `TMC_EDGE_FALL) || (edge_sel == `TMC_EDGE_BOTH);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1           <= 1'b0;
            s2           <= 1'b0;
            level        <= 1'b0;
            first_done   <= 1'b0;
            valid_edge   <= 1'b0;
            reverse_edge <= 1'b0;
        end else if (ce) begin
            valid_edge   <= 1'b0;
            reverse_edge <= 1'b0;
            if (!run) begin
                // inputs ignored while stopped; after the first run, track the level
                if (first_done) begin
                    level <= pin;
                    s1    <= pin;
                    s2    <= pin;
                end
            end else if (sample) begin
                first_done <= 1'b1;
                s1 <= pin;
                s2 <= s1;
                // valid only after two equal samples in a row
                if (rise || fall) begin
                    level        <= s1;
                    valid_edge   <= (rise & want_rise) | (fall & want_fall);
                    reverse_edge <= (rise & ~want_rise) | (fall & ~want_fall);
                end
            end
        end
    end
endmodule

// ### tmc_timer16.v
`timescale 1ns/1ps
`include "tmc_map.vh"
// Notes on behaviour
// - mode 00 stop, 01 free, 10 edge clear
// - preset pair: keep, low, high, prohibited
// - preset 00 keeps present output level
// - output starts from the preset level
// - start may jitter one count clock
// - capture completes even during read
// - overflow also on match clear at FFFF
// - overflow clear before 0001 is lost
// - one-shot only in free or edge clear
// - capture on count-clock input unreliable
// - capture on falling, interrupt on rising tick
// - reverse capture no irq; b edge irq
// - first enable sees high level as rise
// - edge valid after two equal samples
// - inputs ignored while stopped
module tmc_timer16 (
    input  wire        CLK,
    input  wire        RST_N,
    input  wire        CE,
    input  wire [3:0]  ADDR,
    input  wire [15:0] WDATA,
    input  wire        WR,
    input  wire        RD,
    output reg  [15:0] RDATA,
    input  wire        CAPTURE_INPUT_A,
    input  wire        CAPTURE_INPUT_B,
    output reg         TIMER_OUTPUT_PIN,
    output reg         MATCH_A_IRQ,
    output reg         MATCH_B_IRQ
);
    reg [1:0]  mode;
    reg        overflow_flag;
    reg [7:0]  output_control_reg;
    reg [7:0]  capctl;
    reg [3:0]  prescaler_mode_reg;
    reg [15:0] up_counter16;
    reg [15:0] capcomp_reg_a;
    reg [15:0] capcomp_reg_b;
    reg        out_ff;
    reg        oneshot_active;
    reg        pend_a;
    reg        pend_b;
    reg        pend_ext;
    reg        ovf_guard;
    reg        cap_a_pend;
    reg        cap_b_pend;
    reg        cap_a_rev;
    reg        restart_pend;
    reg [15:0] next_count;

    wire run       = (mode != `TMC_MODE_STOP);
    wire ext_clk   = prescaler_mode_reg[`TMC_PR_EXT_CLK];
    wire wr_ctrl   = WR && (ADDR == `TMC_REG_CTRL);
    wire wr_oc     = WR && (ADDR == `TMC_REG_OUTCTL);
    wire [1:0] preset_w = {WDATA[`TMC_OC_PRESET_HIGH], WDATA[`TMC_OC_PRESET_LOW]};
    wire rise_tick;
    wire fall_tick;
    wire edge_a;
    wire rev_a;
    wire edge_b;

    tmc_prescaler #(
        .SEL_W (`TMC_PRESCALE_W)
    ) u_pre (
        .clk       (CLK),
        .rst_n     (RST_N),
        .ce        (CE),
        .run       (run),
        .sel       (prescaler_mode_reg[`TMC_PRESCALE_W-1:0]),
        .rise_tick (rise_tick),
        .fall_tick (fall_tick)
    );

    // input a is sampled on the peripheral clock when it is the count clock
    tmc_edge_filter u_fa (
        .clk          (CLK),
        .rst_n        (RST_N),
        .ce           (CE),
        .run          (run),
        .sample       (ext_clk | rise_tick),
        .pin          (CAPTURE_INPUT_A),
        .edge_sel     ({capctl[`TMC_CC_EDGE_A_HI], capctl[`TMC_CC_EDGE_A_LO]}),
        .valid_edge   (edge_a),
        .reverse_edge (rev_a)
    );

    tmc_edge_filter u_fb (
        .clk          (CLK),
        .rst_n        (RST_N),
        .ce           (CE),
        .run          (run),
        .sample       (rise_tick),
        .pin          (CAPTURE_INPUT_B),
        .edge_sel     ({capctl[`TMC_CC_EDGE_B_HI], capctl[`TMC_CC_EDGE_B_LO]}),
        .valid_edge   (edge_b),
        .reverse_edge ()
    );

    wire count_tick = ext_clk ? edge_a : rise_tick;
    wire match_a    = (up_counter16 == capcomp_reg_a);
    wire match_b    = (up_counter16 == capcomp_reg_b);
    wire a_is_cap   = capctl[`TMC_CC_A_CAPTURE];
    wire b_is_cap   = capctl[`TMC_CC_B_CAPTURE];
    wire rev_sel    = capctl[`TMC_CC_A_REVERSE];
    wire oneshot_ok = (mode == `TMC_MODE_FREE) || (mode == `TMC_MODE_CLR_EDGE);
    wire clr_match  = (mode == `TMC_MODE_CLR_MATCH) && match_a && !a_is_cap;
    wire true_ovf   = (up_counter16 == `TMC_CNT_MAX);
    // a-input valid-edge capture and restart are disabled while a is the count clock; reverse-edge capture into a still works
    wire trig_a     = edge_a && !ext_clk;

    always @* begin
        next_count = up_counter16 + `TMC_CNT_ONE;
        if (clr_match || restart_pend)
            next_count = `TMC_CNT_ZERO;
    end

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode               <= `TMC_MODE_STOP;
            overflow_flag      <= 1'b0;
            output_control_reg <= 8'h00;
            capctl             <= 8'h00;
            prescaler_mode_reg <= 4'h0;
            up_counter16       <= 16'h0000;
            capcomp_reg_a      <= 16'h0000;
            capcomp_reg_b      <= 16'h0000;
            out_ff             <= 1'b0;
            oneshot_active     <= 1'b0;
            pend_a             <= 1'b0;
            pend_b             <= 1'b0;
            pend_ext           <= 1'b0;
            ovf_guard          <= 1'b0;
            cap_a_pend         <= 1'b0;
            cap_b_pend         <= 1'b0;
            cap_a_rev          <= 1'b0;
            restart_pend       <= 1'b0;
            MATCH_A_IRQ        <= 1'b0;
            MATCH_B_IRQ        <= 1'b0;
            TIMER_OUTPUT_PIN   <= 1'b0;
        end else if (CE) begin
            MATCH_A_IRQ <= 1'b0;
            MATCH_B_IRQ <= 1'b0;
            // software writes
            if (wr_ctrl) begin
                mode <= WDATA[`TMC_CTRL_MODE_HI:`TMC_CTRL_MODE_LO];
                if (!WDATA[`TMC_CTRL_OVF])
                    overflow_flag <= 1'b0;
            end
            if (wr_oc) begin
                output_control_reg <= WDATA[7:0];
                // preset acts only while stopped; 00 and 11 leave the output as is
                if (!run) begin
                    if (preset_w == `TMC_PRESET_LOW)
                        out_ff <= 1'b0;
                    else if (preset_w == `TMC_PRESET_HIGH)
                        out_ff <= 1'b1;
                end
            end
            if (WR && ADDR == `TMC_REG_CAPCTL)
                capctl <= WDATA[7:0];
            if (WR && ADDR == `TMC_REG_PRESCALE)
                prescaler_mode_reg <= WDATA[3:0];
            if (WR && ADDR == `TMC_REG_CCA)
                capcomp_reg_a <= WDATA;
            if (WR && ADDR == `TMC_REG_CCB)
                capcomp_reg_b <= WDATA;

            if (!run) begin
                // counter and pending flags clear; overflow flag and output (preset) hold for the start
                up_counter16   <= `TMC_CNT_ZERO;
                oneshot_active <= 1'b0;
                pend_a         <= 1'b0;
                pend_b         <= 1'b0;
                pend_ext       <= 1'b0;
                cap_a_pend     <= 1'b0;
                cap_b_pend     <= 1'b0;
                restart_pend   <= 1'b0;
                ovf_guard      <= 1'b0;
            end else begin
                // latch input events: captures until the next falling count-clock edge, irq and restart until the next rising one
                // register b captures on the valid edge of input a when set to capture
                if (trig_a && b_is_cap) begin
                    cap_b_pend <= 1'b1;
                end
                if (rev_a && a_is_cap && rev_sel) begin
                    cap_a_pend <= 1'b1;
                    cap_a_rev  <= 1'b1;
                end
                if (edge_b) begin
                    if (rev_sel)
                        pend_ext <= 1'b1;
                    else if (a_is_cap) begin
                        cap_a_pend <= 1'b1;
                        cap_a_rev  <= 1'b0;
                    end
                end
                if (trig_a && mode == `TMC_MODE_CLR_EDGE)
                    restart_pend <= 1'b1;
                // captures complete regardless of reads
                if (fall_tick) begin
                    if (cap_a_pend) begin
                        capcomp_reg_a <= up_counter16;
                        pend_a        <= ~cap_a_rev;
                        cap_a_pend    <= 1'b0;
                    end
                    if (cap_b_pend) begin
                        capcomp_reg_b <= up_counter16;
                        pend_b        <= 1'b1;
                        cap_b_pend    <= 1'b0;
                    end
                end
                if (rise_tick && (pend_a || pend_b || pend_ext)) begin
                    MATCH_A_IRQ <= pend_a | pend_ext;
                    MATCH_B_IRQ <= pend_b;
                    pend_a      <= 1'b0;
                    pend_b      <= 1'b0;
                    pend_ext    <= 1'b0;
                end
                if (count_tick) begin
                    up_counter16 <= next_count;
                    restart_pend <= 1'b0;
                    if (!a_is_cap && match_a) begin
                        MATCH_A_IRQ <= 1'b1;
                        if (output_control_reg[`TMC_OC_TOGGLE_A])
                            out_ff <= ~out_ff;
                        if (oneshot_active)
                            oneshot_active <= 1'b0;
                    end
                    if (!b_is_cap && match_b) begin
                        MATCH_B_IRQ <= 1'b1;
                        if (output_control_reg[`TMC_OC_TOGGLE_B])
                            out_ff <= ~out_ff;
                    end
                    // overflow by wrap or by clear from FFFF on match a
                    if (true_ovf && !restart_pend) begin
                        overflow_flag <= 1'b1;
                        ovf_guard     <= 1'b1;
                    end else if (next_count == `TMC_CNT_ONE) begin
                        ovf_guard <= 1'b0;
                    end
                end
                // one-shot trigger, ignored in match-clear mode
                // placed after the tick so a trigger on a tick cycle is not lost
                if (wr_oc && WDATA[`TMC_OC_ONESHOT_TRG] && WDATA[`TMC_OC_ONESHOT_EN]
                    && oneshot_ok) begin
                    restart_pend   <= 1'b1;
                    oneshot_active <= 1'b1;
                end
                // a clear before the counter reaches 0001 does not stick
                if (ovf_guard)
                    overflow_flag <= 1'b1;
            end
            TIMER_OUTPUT_PIN <= out_ff;
        end
    end

    // read data one cycle after the strobe
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= 16'h0000;
        end else if (CE) begin
            RDATA <= 16'h0000;
            if (RD) begin
                case (ADDR)
                    `TMC_REG_CTRL:     RDATA <= {12'h000, mode, 1'b0, overflow_flag};
                    `TMC_REG_OUTCTL:   RDATA <= {8'h00, output_control_reg};
                    `TMC_REG_CAPCTL:   RDATA <= {8'h00, capctl};
                    `TMC_REG_PRESCALE: RDATA <= {12'h000, prescaler_mode_reg};
                    `TMC_REG_COUNT:    RDATA <= up_counter16;
                    `TMC_REG_CCA:      RDATA <= capcomp_reg_a;
                    `TMC_REG_CCB:      RDATA <= capcomp_reg_b;
                    `TMC_REG_STATUS:   RDATA <= {14'h0000, oneshot_active, out_ff};
                    default:           RDATA <= 16'h0000;
                endcase
            end
        end
    end
endmodule

// ### tmc_timer16_assertions.sv
`timescale 1ns/1ps
module tmc_chk (
    input wire        CLK,
    input wire        RST_N,
    input wire        CE,
    input wire [3:0]  ADDR,
    input wire [15:0] WDATA,
    input wire        WR,
    input wire        RD,
    input wire [15:0] RDATA,
    input wire        CAPTURE_INPUT_A,
    input wire        CAPTURE_INPUT_B,
    input wire        TIMER_OUTPUT_PIN,
    input wire        MATCH_A_IRQ,
    input wire        MATCH_B_IRQ
);
    reg  [1:0] mode_q;
    reg  [2:0] stop_cnt;
    wire       stopped = mode_q == 2'h0;
    wire       oc_wr   = stopped && WR && CE && ADDR == 4'h1;

    // shadow of the mode field, and how long the counter has been held stopped
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_q   <= 2'h0;
            stop_cnt <= 3'h0;
        end else begin
            if (WR && CE && ADDR == 4'h0) begin
                mode_q <= WDATA[3:2];
            end
            if (!stopped) begin
                stop_cnt <= 3'h0;
            end else if (stop_cnt != 3'h7) begin
                stop_cnt <= stop_cnt + 3'h1;
            end
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    a_preset_high: assert property (
        oc_wr && WDATA[3:2] == 2'h2 |-> ##2 TIMER_OUTPUT_PIN)
        else $error("preset high not driven");
    a_preset_low: assert property (
        oc_wr && WDATA[3:2] == 2'h1 |-> ##2 !TIMER_OUTPUT_PIN)
        else $error("preset low not driven");
    a_preset_keep: assert property (
        oc_wr && WDATA[3:2] == 2'h0 |-> ##2 TIMER_OUTPUT_PIN == $past(TIMER_OUTPUT_PIN))
        else $error("output moved on keep preset");
    a_start_level: assert property (
        stopped && WR && CE && ADDR == 4'h0 && WDATA[3:2] != 2'h0
        |-> ##2 TIMER_OUTPUT_PIN == $past(TIMER_OUTPUT_PIN))
        else $error("output left preset level at start");
    a_stop_quiet_a: assert property (
        stop_cnt == 3'h7 |-> !MATCH_A_IRQ)
        else $error("irq a while stopped");
    a_stop_quiet_b: assert property (
        stop_cnt == 3'h7 |-> !MATCH_B_IRQ)
        else $error("irq b while stopped");
    a_irq_a_single: assert property (
        MATCH_A_IRQ |=> !MATCH_A_IRQ)
        else $error("irq a longer than one cycle");
    a_irq_b_single: assert property (
        $rose(MATCH_B_IRQ) |=> !MATCH_B_IRQ)
        else $error("irq b longer than one cycle");
endmodule

bind tmc_timer16 tmc_chk u_chk (
    .CLK(CLK), .RST_N(RST_N), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .CAPTURE_INPUT_A(CAPTURE_INPUT_A), .CAPTURE_INPUT_B(CAPTURE_INPUT_B),
    .TIMER_OUTPUT_PIN(TIMER_OUTPUT_PIN), .MATCH_A_IRQ(MATCH_A_IRQ), .MATCH_B_IRQ(MATCH_B_IRQ)
);

// ### tmc_pulse_src.sv
`timescale 1ns/1ps
module tmc_pulse_src (
    input  wire clk,
    output reg  pin_a,
    output reg  pin_b
);
    initial begin
        pin_a = 1'b0;
        pin_b = 1'b0;
    end

    // set a level just after an edge and hold it for a number of clocks
    task automatic drive(input bit sel_b, input bit lvl, input int hold);
        @(posedge clk);
        if (sel_b) begin
            pin_b <= lvl;
        end else begin
            pin_a <= lvl;
        end
        repeat (hold) @(posedge clk);
    endtask

    // width 0 gives a one-clock glitch, used only to probe the noise filter
    task automatic pulse(input bit sel_b, input int width);
        drive(sel_b, 1'b1, width);
        drive(sel_b, 1'b0, 6);
    endtask
endmodule

// ### tmc_timer16_bench.sv
`timescale 1ns/1ps
module tmc_timer16_bench;
    reg         clk;
    reg         rst_n;
    reg         ce;
    reg  [3:0]  addr;
    reg  [15:0] wdata;
    reg         wr;
    reg         rd;
    wire [15:0] rdata;
    wire        in_a;
    wire        in_b;
    wire        pin;
    wire        irq_a;
    wire        irq_b;
    int         err_count;
    int         samples_checked;
    int         cyc;
    int         at;
    int         cs;
    int         ce_at;
    int         n;
    int         m;
    int         i;
    reg  [15:0] got;

    tmc_timer16 u_dut (
        .CLK(clk), .RST_N(rst_n), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .CAPTURE_INPUT_A(in_a), .CAPTURE_INPUT_B(in_b),
        .TIMER_OUTPUT_PIN(pin), .MATCH_A_IRQ(irq_a), .MATCH_B_IRQ(irq_b)
    );
    tmc_pulse_src u_src (
        .clk(clk),
        .pin_a(in_a),
        .pin_b(in_b)
    );

    always #20 clk = ~clk;

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    function automatic [15:0] near(input [15:0] v, input int ref_v);
        near = {15'h0, (int'(v) >= ref_v - 3) && (int'(v) <= ref_v + 6)};
    endfunction

    task automatic check(input [15:0] g, input [15:0] e);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr_reg(input [3:0] a, input [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input [3:0] a, output [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic pin_is(input bit v);
        @(posedge clk);
        #1;
        check({15'h0, pin}, {15'h0, v});
    endtask

    // waits up to lim clocks for an irq pulse; at returns the wait in clocks
    task automatic expect_irq(input bit sel_b, input bit want, input int lim, output int at_v);
        bit seen;
        seen = 1'b0;
        at_v = 0;
        while (!seen && at_v < lim) begin
            @(posedge clk);
            #1;
            at_v++;
            seen = (sel_b ? irq_b : irq_a) === 1'b1;
        end
        check({15'h0, seen}, {15'h0, want});
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        ce = 1'b1;
        addr = 4'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        cyc = 0;
        err_count = 0;
        samples_checked = 0;
        void'($urandom(78641));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        u_src.drive(0, 1'b1, 4);
        wr_reg(4'h2, 16'h0014);
        wr_reg(4'h0, 16'h0004);
        expect_irq(1, 1, 24, at);
        wr_reg(4'h0, 16'h0000);
        wr_reg(4'h0, 16'h0004);
        expect_irq(1, 0, 24, at);
        wr_reg(4'h0, 16'h0000);
        u_src.drive(0, 1'b0, 2);
        rd_reg(4'hF, got);
        check(got, 16'h0000);
        $display("test first_enable done");

        n = 16 + $urandom % 32;
        wr_reg(4'h3, 16'h0000);
        wr_reg(4'h2, 16'h0000);
        wr_reg(4'h5, n[15:0]);
        wr_reg(4'h1, 16'h0008);
        pin_is(1'b1);
        wr_reg(4'h1, 16'h0000);
        pin_is(1'b1);
        wr_reg(4'h1, 16'h0004);
        pin_is(1'b0);
        wr_reg(4'h1, 16'h0008);
        pin_is(1'b1);
        wr_reg(4'h1, 16'h0001);
        wr_reg(4'h0, 16'h0004);
        pin_is(1'b1);
        expect_irq(0, 1, 2 * n + 20, at);
        check(near(at[15:0], 2 * n - 1), 16'h0001);
        wr_reg(4'h0, 16'h0000);
        wr_reg(4'h1, 16'h0004);
        wr_reg(4'h1, 16'h0000);
        $display("test preset_start done");

        wr_reg(4'h2, 16'h0041);
        fork
            u_src.pulse(1, 10);
            expect_irq(0, 0, 30, at);
        join
        wr_reg(4'h0, 16'h0004);
        cs = cyc;
        for (i = 0; i < 4; i++) begin
            ce_at = cyc;
            fork
                u_src.pulse(1, 5 + $urandom % 20);
                expect_irq(0, 1, 40, at);
            join
            rd_reg(4'h5, got);
            check(near(got, (ce_at - cs) / 2), 16'h0001);
        end
        fork
            u_src.pulse(1, 0);
            expect_irq(0, 0, 30, at);
        join
        $display("test capture done");

        wr_reg(4'h0, 16'h0000);
        wr_reg(4'h2, 16'h0053);
        wr_reg(4'h0, 16'h0004);
        fork
            u_src.pulse(1, 8);
            expect_irq(0, 1, 40, at);
        join
        fork
            u_src.pulse(0, 8);
            expect_irq(0, 0, 40, at);
        join
        wr_reg(4'h0, 16'h0000);
        $display("test reverse_phase done");

        // pulse pattern in match-clear mode, then a duty change of register b
        n = 8 + $urandom % 16;
        m = 2 + $urandom % 4;
        wr_reg(4'h2, 16'h0000);
        wr_reg(4'h5, n[15:0]);
        wr_reg(4'h6, m[15:0]);
        wr_reg(4'h1, 16'h0011);
        wr_reg(4'h0, 16'h000C);
        expect_irq(0, 1, 2 * n + 20, at);
        expect_irq(1, 1, 2 * n + 8, at);
        got = 2 * m + 2;
        check(at[15:0], got);
        expect_irq(0, 1, 2 * n + 8, at);
        got = 2 * (n - m);
        check(at[15:0], got);
        wr_reg(4'h1, 16'h0001);
        m = m + 1;
        wr_reg(4'h6, m[15:0]);
        repeat (2) @(posedge clk);
        wr_reg(4'h1, 16'h0011);
        expect_irq(0, 1, 2 * n + 8, at);
        expect_irq(1, 1, 2 * n + 8, at);
        got = 2 * m + 2;
        check(at[15:0], got);
        wr_reg(4'h1, 16'h0071);
        rd_reg(4'h7, got);
        check(got & 16'h0002, 16'h0000);
        wr_reg(4'h0, 16'h0000);
        wr_reg(4'h0, 16'h0004);
        wr_reg(4'h1, 16'h0071);
        rd_reg(4'h7, got);
        check(got & 16'h0002, 16'h0002);
        expect_irq(0, 1, 2 * n + 8, at);
        rd_reg(4'h7, got);
        check(got & 16'h0002, 16'h0000);
        wr_reg(4'h0, 16'h0000);
        $display("test pattern_oneshot done");

        // input a as count clock: every rising edge counts, no capture into b
        wr_reg(4'h1, 16'h0000);
        wr_reg(4'h3, 16'h0008);
        wr_reg(4'h2, 16'h0014);
        wr_reg(4'h0, 16'h0004);
        for (i = 0; i < 3; i++) begin
            fork
                u_src.pulse(0, 3);
                expect_irq(1, 0, 12, at);
            join
        end
        rd_reg(4'h4, got);
        check(got, 16'h0003);
        wr_reg(4'h0, 16'h0000);
        wr_reg(4'h3, 16'h0000);
        $display("test external_count done");
        end_of_test();
    end
endmodule
